/* core/instr_decoder.sv */
// How it works
// RQ1 - 14-bit word splits into class/opcode bits and operand fields
// RQ2 - target bit zero writes accumulator, one writes the addressed file register
// RQ3 - register index is the low seven bits, addresses 0x00..0x7f
// RQ4 - bit position field picks one of eight bits in the file register
// RQ5 - literal ops take an 8-bit immediate, jumps an 11-bit one
// RQ6 - one instruction cycle is four oscillator periods
// RQ7 - one cycle per instruction; taken test or pc change adds a NOP cycle
// RQ8 - file register ops always read, then modify, then store
// RQ9 - don't-care encoding bits never change decoding
// RQ10 - decrement_skip_if_zero (00 1011) skips on zero, taking two cycles then
// RQ11 - increment_skip_if_zero (00 1111) skips on zero, taking two cycles then
// RQ12 - a zero skip result turns the next fetched instruction into a NOP
// RQ13 - zero-affecting instructions set null_result_flag on zero result, else clear
`timescale 1ns/1ns
module instr_decoder
   import instr_decoder_pkg::*;
(
   input  wire logic                           clk,
   input  wire logic                           srst,
   input  wire logic [instr_decoder_pkg::WORD_WIDTH-1:0]      instrWord,
   input  wire logic [instr_decoder_pkg::DATA_WIDTH-1:0]      fileRdData,
   output logic      [instr_decoder_pkg::PC_WIDTH-1:0]        programCounter,
   output logic      [instr_decoder_pkg::FILE_ADDR_WIDTH-1:0] fileAddr,
   output logic                                               fileRd,
   output logic                                               fileWr,
   output logic      [instr_decoder_pkg::DATA_WIDTH-1:0]      fileWrData,
   output logic      [instr_decoder_pkg::DATA_WIDTH-1:0]      accumulator,
   output logic                                               nullResultFlag,
   output logic                                               carryFlag,
   output logic                                               nopCycle,
   output logic                                               cycleStart
);
   import instr_decoder_pkg::*;

   typedef struct packed {
      phase_e                     phase;
      logic [WORD_WIDTH-1:0]      ir;
      logic                       flush;
      logic [DATA_WIDTH-1:0]      opA;
      logic [DATA_WIDTH-1:0]      result;
      logic                       wrFile;
      logic                       wrAcc;
      logic                       setZ;
      logic                       skip;
      logic [PC_WIDTH-1:0]        pc;
      logic [PC_WIDTH-1:0]        pcLoad;
      logic                       pcJump;
      logic [FILE_ADDR_WIDTH-1:0] addr;
      logic                       rd;
      logic                       wr;
      logic [DATA_WIDTH-1:0]      wdata;
      logic [DATA_WIDTH-1:0]      w;
      logic                       z;
      logic                       c;
      logic                       nop;
      logic                       start;
   } state_s;

   state_s st;
   state_s next_st;

   // decoded fields of the held instruction
   logic [1:0]                 cls;
   logic [3:0]                 bop;
   logic [1:0]                 bitOp;
   logic                       toFile;
   logic [FILE_ADDR_WIDTH-1:0] fAddr;
   logic [BIT_SEL_WIDTH-1:0]   bitSel;
   logic [SHORT_K_WIDTH-1:0]   kShort;
   logic [LONG_K_WIDTH-1:0]    kLong;
   logic [DATA_WIDTH-1:0]      bitMask;
   logic [DATA_WIDTH:0]        sum;

   // field split of the 14-bit word
   assign cls     = st.ir[CLASS_MSB:CLASS_LSB];                            // [RQ1]
   assign bop     = st.ir[BYTE_OP_LSB+3:BYTE_OP_LSB];                      // [RQ1]
   assign bitOp   = st.ir[BIT_OP_LSB+1:BIT_OP_LSB];
   assign toFile  = st.ir[TARGET_BIT];                                     // [RQ2]
   assign fAddr   = st.ir[FILE_ADDR_LSB+FILE_ADDR_WIDTH-1:FILE_ADDR_LSB];  // [RQ3]
   assign bitSel  = st.ir[BIT_SEL_LSB+BIT_SEL_WIDTH-1:BIT_SEL_LSB];        // [RQ4]
   assign kShort  = st.ir[SHORT_K_WIDTH-1:0];                              // [RQ5]
   assign kLong   = st.ir[LONG_K_WIDTH-1:0];                               // [RQ5]
   assign bitMask = DATA_WIDTH'(1) << bitSel;                              // [RQ4]

   always_comb begin
      next_st       = st;
      next_st.start = 1'b0;
      next_st.rd    = 1'b0;
      next_st.wr    = 1'b0;
      sum           = '0;
      // four phases make one instruction cycle
      unique case (st.phase)                                               // [RQ6]
         PH_READ: begin
            // read happens even for write-only ops like clear
            next_st.phase = PH_MODIFY;
            next_st.addr  = fAddr;
            next_st.rd    = !st.flush && (cls == CLASS_BYTE || cls == CLASS_BIT); // [RQ8]
         end
         PH_MODIFY: begin
            next_st.phase  = PH_STORE;
            next_st.opA    = fileRdData;
            next_st.wrFile = 1'b0;
            next_st.wrAcc  = 1'b0;
            next_st.setZ   = 1'b0;
            next_st.skip   = 1'b0;
            next_st.pcJump = 1'b0;
            next_st.result = fileRdData;
            if (!st.flush) begin
               unique case (cls)
                  CLASS_BYTE: begin
                     next_st.wrFile = toFile;                              // [RQ2]
                     next_st.wrAcc  = !toFile;                             // [RQ2]
                     next_st.setZ   = 1'b1;
                     unique case (bop)
                        OP_MISC: begin
                           // 0x00 move accumulator to file; others treated as nop
                           next_st.setZ   = 1'b0;
                           next_st.wrAcc  = 1'b0;
                           next_st.result = st.w;
                        end
                        OP_CLR: begin
                           // clear: low seven bits ignored when clearing w
                           next_st.result = '0;                            // [RQ9]
                        end
                        OP_SUB: begin
                           sum            = {1'b0, fileRdData} + {1'b0, ~st.w} + 9'h001;
                           next_st.result = sum[DATA_WIDTH-1:0];
                        end
                        OP_DEC:    next_st.result = fileRdData - 8'h01;
                        OP_IOR:    next_st.result = fileRdData | st.w;
                        OP_AND:    next_st.result = fileRdData & st.w;
                        OP_XOR:    next_st.result = fileRdData ^ st.w;
                        OP_ADD: begin
                           sum            = {1'b0, fileRdData} + {1'b0, st.w};
                           next_st.result = sum[DATA_WIDTH-1:0];
                        end
                        OP_MOV:    next_st.result = fileRdData;
                        OP_COM:    next_st.result = ~fileRdData;
                        OP_INC:    next_st.result = fileRdData + 8'h01;
                        OP_DECSKP: begin
                           next_st.setZ   = 1'b0;
                           next_st.result = fileRdData - 8'h01;
                           next_st.skip   = (fileRdData == 8'h01);         // [RQ10]
                        end
                        OP_INCSKP: begin
                           next_st.setZ   = 1'b0;
                           next_st.result = fileRdData + 8'h01;
                           next_st.skip   = (fileRdData == 8'hff);         // [RQ11]
                        end
                        default: begin
                           // rotates and swap are outside this decoder's map
                           next_st.setZ  = 1'b0;
                           next_st.wrAcc = !toFile;
                        end
                     endcase
                     if (bop == OP_MISC) begin
                        next_st.wrFile = toFile;
                     end
                     if (bop == OP_CLR) begin
                        next_st.wrFile = toFile;
                        next_st.wrAcc  = !toFile;
                     end
                  end
                  CLASS_BIT: begin
                     unique case (bitOp)
                        BOP_CLR: begin
                           next_st.result = fileRdData & ~bitMask;         // [RQ4]
                           next_st.wrFile = 1'b1;
                        end
                        BOP_SET: begin
                           next_st.result = fileRdData | bitMask;          // [RQ4]
                           next_st.wrFile = 1'b1;
                        end
                        BOP_TSTC: next_st.skip = (fileRdData & bitMask) == '0;
                        BOP_TSTS: next_st.skip = (fileRdData & bitMask) != '0;
                     endcase
                  end
                  CLASS_JUMP: begin
                     next_st.pcJump = 1'b1;                                // [RQ5]
                     next_st.pcLoad = {st.pc[PC_WIDTH-1:LONG_K_WIDTH], kLong};
                  end
                  CLASS_LIT: begin
                     // literal move into the accumulator
                     next_st.result = kShort;                              // [RQ5]
                     next_st.wrAcc  = 1'b1;
                  end
               endcase
            end
         end
         PH_STORE: begin
            next_st.phase = PH_FETCH;
            next_st.wr    = st.wrFile;                                     // [RQ8]
            next_st.wdata = st.result;
            if (st.wrAcc) begin
               next_st.w = st.result;                                      // [RQ2]
            end
            if (st.setZ) begin
               next_st.z = (st.result == '0);                              // [RQ13]
            end
         end
         PH_FETCH: begin
            next_st.phase = PH_READ;
            next_st.start = 1'b1;
            next_st.ir    = instrWord;
            // taken skip or jump turns the next cycle into a NOP
            next_st.flush = st.skip || st.pcJump;                          // [RQ7] [RQ12]
            next_st.nop   = st.skip || st.pcJump;                          // [RQ7]
            next_st.pc    = st.pcJump ? st.pcLoad : st.pc + 13'h0001;
         end
      endcase
      if (st.phase == PH_MODIFY && cls == CLASS_BYTE && (bop == OP_ADD || bop == OP_SUB)
          && !st.flush) begin
         next_st.c = sum[DATA_WIDTH];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st       <= '0;
         st.phase <= PH_READ;
         st.pc    <= PC_RESET;
         st.flush <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign programCounter = st.pc;
   assign fileAddr       = st.addr;
   assign fileRd         = st.rd;
   assign fileWr         = st.wr;
   assign fileWrData     = st.wdata;
   assign accumulator    = st.w;
   assign nullResultFlag = st.z;
   assign carryFlag      = st.c;
   assign nopCycle       = st.nop;
   assign cycleStart     = st.start;

   // cycle counter for assertions; cleared as a start is launched so the
   // reset cycle, which starts without a pulse, counts like any other
   logic [2:0] sinceStart;
   always_ff @(posedge clk) begin
      if (srst || next_st.start) begin
         sinceStart <= '0;
      end else begin
         sinceStart <= sinceStart + 3'h1;
      end
   end

   AST_FOUR_PERIODS: assert property (@(posedge clk) disable iff (srst)  // [RQ6]
      st.start |=> !st.start [*3] ##1 st.start) else $error("cycle not four periods");
   AST_CNT_BOUND: assert property (@(posedge clk) disable iff (srst)  // [RQ6]
      sinceStart <= 3'h3) else $error("cycle overran");
   AST_RMW_ORDER: assert property (@(posedge clk) disable iff (srst)  // [RQ8]
      st.wr |-> $past(st.rd, 2)) else $error("store without read");
   AST_RD_PHASE: assert property (@(posedge clk) disable iff (srst)  // [RQ8]
      st.rd |-> st.phase == PH_MODIFY) else $error("read in wrong phase");
   AST_SKIP_NOP: assert property (@(posedge clk) disable iff (srst)  // [RQ12]
      (st.phase == PH_FETCH && st.skip) |=> st.nop && st.flush) else $error("skip not nopped");
   AST_NOP_NOWRITE: assert property (@(posedge clk) disable iff (srst)  // [RQ7]
      (st.start && st.nop) |-> ##1 !st.rd ##1 1'b1 ##1 !st.wr) else $error("nop cycle wrote");
   AST_ZERO_FLAG: assert property (@(posedge clk) disable iff (srst)  // [RQ13]
      (st.phase == PH_STORE && st.setZ) |=> st.z == (st.result == '0)) else $error("zero flag wrong");
   AST_ACC_TARGET: assert property (@(posedge clk) disable iff (srst)  // [RQ2]
      (st.phase == PH_STORE && st.wrAcc) |=> st.w == $past(st.result) && !st.wr)
      else $error("accumulator target wrong");
   AST_JUMP_PC: assert property (@(posedge clk) disable iff (srst)  // [RQ7]
      (st.phase == PH_FETCH && st.pcJump) |=> st.pc == $past(st.pcLoad)) else $error("jump pc wrong");

   COV_SKIP: cover property (@(posedge clk) st.start && st.nop);
   COV_FILE_WR: cover property (@(posedge clk) st.wr);
   COV_ZERO: cover property (@(posedge clk) $rose(st.z));
endmodule

/* core/instr_decoder_pkg.sv */
package instr_decoder_pkg;

   localparam int WORD_WIDTH      = 14;
   localparam int DATA_WIDTH      = 8;
   localparam int FILE_ADDR_WIDTH = 7;
   localparam int BIT_SEL_WIDTH   = 3;
   localparam int SHORT_K_WIDTH   = 8;
   localparam int LONG_K_WIDTH    = 11;
   localparam int PC_WIDTH        = 13;

   // field positions within the instruction word
   localparam int FILE_ADDR_LSB  = 0;
   localparam int TARGET_BIT     = 7;
   localparam int BIT_SEL_LSB    = 7;
   localparam int CLASS_MSB      = 13;
   localparam int CLASS_LSB      = 12;
   localparam int BYTE_OP_LSB    = 8;
   localparam int BIT_OP_LSB     = 10;

   // instruction-class prefixes
   localparam logic [1:0] CLASS_BYTE = 2'h0;
   localparam logic [1:0] CLASS_BIT  = 2'h1;
   localparam logic [1:0] CLASS_JUMP = 2'h2;
   localparam logic [1:0] CLASS_LIT  = 2'h3;

   // byte-oriented operation nibbles
   localparam logic [3:0] OP_MISC   = 4'h0;
   localparam logic [3:0] OP_CLR    = 4'h1;
   localparam logic [3:0] OP_SUB    = 4'h2;
   localparam logic [3:0] OP_DEC    = 4'h3;
   localparam logic [3:0] OP_IOR    = 4'h4;
   localparam logic [3:0] OP_AND    = 4'h5;
   localparam logic [3:0] OP_XOR    = 4'h6;
   localparam logic [3:0] OP_ADD    = 4'h7;
   localparam logic [3:0] OP_MOV    = 4'h8;
   localparam logic [3:0] OP_COM    = 4'h9;
   localparam logic [3:0] OP_INC    = 4'ha;
   localparam logic [3:0] OP_DECSKP = 4'hb;
   localparam logic [3:0] OP_INCSKP = 4'hf;

   // bit-oriented operation codes
   localparam logic [1:0] BOP_CLR  = 2'h0;
   localparam logic [1:0] BOP_SET  = 2'h1;
   localparam logic [1:0] BOP_TSTC = 2'h2;
   localparam logic [1:0] BOP_TSTS = 2'h3;

   // index of the last oscillator period in an instruction cycle
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam logic [PC_WIDTH-1:0] PC_RESET = 13'h0000;

   typedef enum logic [1:0] {
      PH_READ   = 2'b00,
      PH_MODIFY = 2'b01,
      PH_STORE  = 2'b10,
      PH_FETCH  = 2'b11
   } phase_e;

endpackage

/* bench/register_file_model.sv */
`timescale 1ns/1ns
module register_file_model
   import instr_decoder_pkg::*;
(
   input  wire logic                                          clk,
   input  wire logic [instr_decoder_pkg::FILE_ADDR_WIDTH-1:0] fileAddr,
   input  wire logic                                          fileRd,
   input  wire logic                                          fileWr,
   input  wire logic [instr_decoder_pkg::DATA_WIDTH-1:0]      fileWrData,
   output logic      [instr_decoder_pkg::DATA_WIDTH-1:0]      fileRdData
);
   logic [DATA_WIDTH-1:0]      mem [128];
   logic [DATA_WIDTH-1:0]      junk = 8'h5a;

   // writes land on the edge that samples the strobe
   always @(posedge clk) begin
      junk <= ~junk;
      if (fileWr)
         mem[fileAddr] <= fileWrData;
   end

   // core samples read data on the edge that ends the strobe, so it stands while the strobe is high;
   // outside the read slot a toggling pattern, so a stale sample cannot pass
   assign fileRdData = fileRd ? mem[fileAddr] : junk;
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
   import instr_decoder_pkg::*;
   logic                       clk;
   logic                       srst;
   logic [WORD_WIDTH-1:0]      instrWord;
   logic [DATA_WIDTH-1:0]      fileRdData;
   logic [PC_WIDTH-1:0]        programCounter;
   logic [FILE_ADDR_WIDTH-1:0] fileAddr;
   logic                       fileRd;
   logic                       fileWr;
   logic [DATA_WIDTH-1:0]      fileWrData;
   logic [DATA_WIDTH-1:0]      accumulator;
   logic                       nullResultFlag;
   logic                       carryFlag;
   logic                       nopCycle;
   logic                       cycleStart;
   int                         fails;
   int                         comparisons;
   int                         seed;
   logic [7:0]                 expMem [128];
   logic [7:0]                 expW;
   logic                       expZ;
   logic                       flushed;
   logic [13:0]                pend;
   logic [6:0]                 lastA;
   logic [6:0]                 rdAddr = 7'h00;
   logic [7:0]                 rdCnt = 8'h00;
   logic [7:0]                 wrCnt = 8'h00;
   logic [7:0]                 clkCnt = 8'h00;
   logic [7:0]                 rdMark;
   logic [7:0]                 wrMark;
   logic [7:0]                 clkMark;
   logic [12:0]                expPc;
   logic                       expC;
   logic                       eRd;
   logic                       eWr;
   logic                       dcRd;
   logic                       first;
   logic [13:0]                corner [7];

   instr_decoder dut (.clk(clk), .srst(srst), .instrWord(instrWord), .fileRdData(fileRdData),
      .programCounter(programCounter), .fileAddr(fileAddr), .fileRd(fileRd), .fileWr(fileWr),
      .fileWrData(fileWrData), .accumulator(accumulator), .nullResultFlag(nullResultFlag),
      .carryFlag(carryFlag), .nopCycle(nopCycle), .cycleStart(cycleStart));

   register_file_model rf (.clk(clk), .fileAddr(fileAddr), .fileRd(fileRd), .fileWr(fileWr),
      .fileWrData(fileWrData), .fileRdData(fileRdData));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // running activity totals; step keeps marks so each total has one writer
   always @(posedge clk) begin
      clkCnt <= clkCnt + 8'h01;
      if (fileRd === 1'b1)
         rdCnt <= rdCnt + 8'h01;
      if (fileRd === 1'b1)
         rdAddr <= fileAddr;
      if (fileWr === 1'b1)
         wrCnt <= wrCnt + 8'h01;
   end

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      if (fails == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   function automatic logic [7:0] alu(input logic [3:0] op, input logic [7:0] f, input logic [7:0] w);
      case (op)
         OP_MISC:           return w;
         OP_CLR:            return 8'h00;
         OP_SUB:            return f - w;
         OP_DEC, OP_DECSKP: return f - 8'h01;
         OP_IOR:            return f | w;
         OP_AND:            return f & w;
         OP_XOR:            return f ^ w;
         OP_ADD:            return f + w;
         OP_COM:            return ~f;
         OP_INC, OP_INCSKP: return f + 8'h01;
         default:           return f;
      endcase
   endfunction

   function automatic logic [13:0] rnd();
      logic [31:0] v;
      v = $random(seed);
      return v[13:0];
   endfunction

   // checks the cycle just ended, then predicts the one starting now
   task automatic step(input logic [13:0] nw);
      logic [7:0] f;
      logic [7:0] r;
      logic [3:0] op;
      logic [2:0] b;
      logic       d;
      logic       nf;
      int         n;
      n = 0;
      @(negedge clk);
      while (cycleStart !== 1'b1 && n < 16) begin
         n++;
         @(negedge clk);
      end
      if (n == 16)
         fails++;
      if (!first)
         cmp(clkCnt - clkMark, 8'h04);
      cmp(accumulator, expW);
      cmp({7'h00, nullResultFlag}, {7'h00, expZ});
      cmp(rf.mem[lastA], expMem[lastA]);
      if (!dcRd)
         cmp(rdCnt - rdMark, {7'h00, eRd});
      if (eRd)
         cmp({1'b0, rdAddr}, {1'b0, lastA});
      cmp(wrCnt - wrMark, {7'h00, eWr});
      cmp({7'h00, nopCycle}, {7'h00, flushed});
      cmp({7'h00, carryFlag}, {7'h00, expC});
      cmp(programCounter[7:0], expPc[7:0]);
      cmp({3'h0, programCounter[12:8]}, {3'h0, expPc[12:8]});
      op = pend[11:8];
      d = pend[7];
      b = pend[9:7];
      lastA = pend[6:0];
      f = expMem[lastA];
      nf = 1'b0;
      eRd = 1'b0;
      eWr = 1'b0;
      dcRd = 1'b0;
      if (!flushed) begin
         case (pend[13:12])
            CLASS_BYTE: begin
               r = alu(op, f, expW);
               // carry is no-borrow for subtract, taken before the accumulator moves
               if (op == OP_ADD)
                  expC = ({1'b0, f} + {1'b0, expW}) > 9'h0ff;
               if (op == OP_SUB)
                  expC = (f >= expW);
               eRd = 1'b1;
               eWr = d;
               dcRd = !d && (op == OP_MISC || op == OP_CLR);
               if (d)
                  expMem[lastA] = r;
               else if (op != OP_MISC)
                  expW = r;
               if (op != OP_MISC && op <= OP_INC)
                  expZ = (r == 8'h00);
               nf = (op == OP_DECSKP || op == OP_INCSKP) && r == 8'h00;
            end
            CLASS_BIT: begin
               eRd = 1'b1;
               eWr = !pend[11];
               if (!pend[11])
                  expMem[lastA][b] = pend[10];
               else
                  nf = (f[b] == pend[10]);
            end
            CLASS_JUMP: nf = 1'b1;
            default: expW = pend[7:0];
         endcase
      end
      // a jump keeps the top two counter bits, everything else steps by one
      if (!flushed && pend[13:12] == CLASS_JUMP)
         expPc = {expPc[12:11], pend[10:0]};
      else
         expPc = expPc + 13'h0001;
      flushed = nf;
      pend = nw;
      instrWord = nw;
      rdMark = rdCnt;
      wrMark = wrCnt;
      clkMark = clkCnt;
      first = 1'b0;
   endtask

   initial begin
      seed = 32'hddf3;
      fails = 0;
      comparisons = 0;
      srst = 1'b1;
      instrWord = 14'h0000;
      {rdMark, wrMark, clkMark} = 24'h000000;
      // the reset cycle carries no skip, so the first checked cycle is live
      {expW, expZ, flushed, pend} = 24'h000000;
      {eRd, eWr, dcRd, first, lastA} = 11'h080;
      expPc = 13'h0001;
      expC = 1'b0;
      // corners each followed by three random steps, ahead of the long random run
      corner = '{14'h0b85, 14'h0f86, 14'h01ff, 14'h017f, 14'h1780, 14'h2123, 14'h3a5a};
      for (int i = 0; i < 128; i++)
         expMem[i] = 8'(rnd());
      expMem[5] = 8'h01;
      expMem[6] = 8'hff;
      rf.mem = expMem;
      repeat (5) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      foreach (corner[i]) begin
         step(corner[i]);
         repeat (3) step(rnd());
      end
      repeat (150) step(rnd());
      step(14'h0000);
      step(14'h0000);
      stop_test();
   end

   // hang guard, well past the expected run of under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test();
   end
endmodule
